// >>> design/sweep_unit_regs.svh
// Constants for the sweep unit
`ifndef SWEEP_UNIT_REGS_SVH
`define SWEEP_UNIT_REGS_SVH
`define SWU_DEST_FREQ    2'h0
`define SWU_DEST_PHASE   2'h1
`define SWU_DWELL_NORMAL 2'h0
`define SWU_DWELL_FALL   2'h1
`define SWU_DWELL_RISE   2'h2
`define SWU_DWELL_CONT   2'h3
`define SWU_CLK_DIV      16
`define SWU_PHASE_W      16
`define SWU_AMP_W        12
`endif

// >>> design/swu_pkg.sv
// Types for the sweep unit
package swu_pkg;
  typedef enum logic [0:0] {
    SWU_FALL = 1'b0,
    SWU_RISE = 1'b1
  } swu_dir_e;
endpackage : swu_pkg

// >>> design/swu_tick_div.sv
// Divider producing the ramp clock enable pulse
`timescale 1ns/100ps
`default_nettype none
module swu_tick_div #(
  parameter int DIV = 16
) (
  input  wire logic clk,   // System clock
  input  wire logic rst,   // Sync reset, high
  input  wire logic run,   // Divider runs when high
  output logic      tick   // One-cycle enable
);
  initial begin
    if (DIV < 2) $error("swu_tick_div: DIV below 2");
  end
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  always_comb begin
    next_count = count;
    if (!run) begin
      next_count = '0;
    end else if (count == CW'(DIV - 1)) begin
      next_count = '0;
    end else begin
      next_count = count + CW'(1);
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
  assign tick = run && (count == CW'(DIV - 1));

  // Separate count since the last tick, so the rate check does not trust count
  localparam int GW = CW + 1;
  logic [GW-1:0] gap_cnt;
  logic [GW-1:0] next_gap_cnt;
  always_comb begin
    next_gap_cnt = gap_cnt + GW'(1);
    if (!run || tick) begin
      next_gap_cnt = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_cnt <= '0;
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end
  tick_rate_a: assert property (@(posedge clk) disable iff (rst)
    run |-> tick == (gap_cnt == GW'(DIV - 1)))
    else $error("ramp tick rate wrong");
endmodule : swu_tick_div
`default_nettype wire

// >>> design/swu_sweep_unit.sv
// Digital ramp sweep unit of a DDS core
`timescale 1ns/100ps
`default_nettype none
`include "sweep_unit_regs.svh"
module swu_sweep_unit #(
  parameter int ACC_W  = 32,
  parameter int TMR_W  = 16
) (
  input  wire logic             clk,            // System clock
  input  wire logic             rst,            // Sync reset, high
  input  wire logic             io_update,      // Register commit strobe
  input  wire logic             ramp_enable,    // Pending ramp enable
  input  wire logic             ramp_clear,     // Pending accumulator clear
  input  wire logic [1:0]       ramp_dest,      // Destination field
  input  wire logic [1:0]       no_dwell,       // Dwell mode field
  input  wire logic [ACC_W-1:0] step_rise,      // Rising step size
  input  wire logic [ACC_W-1:0] step_fall,      // Falling step size
  input  wire logic [TMR_W-1:0] rate_rise,      // Rising interval P
  input  wire logic [TMR_W-1:0] rate_fall,      // Falling interval N
  input  wire logic [ACC_W-1:0] limit_upper,    // Upper limit
  input  wire logic [ACC_W-1:0] limit_lower,    // Lower limit
  input  wire logic             ramp_direction_pin, // Direction pin
  input  wire logic             ramp_freeze_pin,    // Hold pin
  input  wire logic [31:0]      prof_freq,      // Profile frequency
  input  wire logic [15:0]      prof_phase,     // Profile phase
  input  wire logic [11:0]      prof_amp,       // Profile amplitude
  output logic      [ACC_W-1:0] ramp_out,       // Ramp value
  output logic      [31:0]      dds_freq,       // Frequency to DDS
  output logic      [15:0]      dds_phase,      // Phase to DDS
  output logic      [11:0]      dds_amp,        // Amplitude to DDS
  output logic                  ramp_active     // Committed enable
);
  initial begin
    if (ACC_W != 32) $error("swu_sweep_unit: ACC_W must be 32");
    if (TMR_W < 1) $error("swu_sweep_unit: TMR_W below 1");
  end

  // Committed control bits
  logic en_q, clr_q;
  logic next_en_q, next_clr_q;
  logic en_rise;
  always_comb begin
    next_en_q  = en_q;
    next_clr_q = clr_q;
    if (io_update) begin
      next_en_q  = ramp_enable;
      next_clr_q = ramp_clear;
    end
  end
  assign en_rise = io_update && ramp_enable && !en_q;

  logic tick;
  // Gating the divider stands in for stopping the ramp clock
  swu_tick_div #(.DIV(`SWU_CLK_DIV)) u_div (
    .clk  (clk),
    .rst  (rst),
    .run  (en_q),
    .tick (tick)
  );

  // Pin synchronisers, advanced on the ramp clock tick
  logic dir_s1, dir_s2, dir_d, hold_s1, hold_s2;
  logic next_dir_s1, next_dir_s2, next_dir_d, next_hold_s1, next_hold_s2;
  always_comb begin
    next_dir_s1  = dir_s1;
    next_dir_s2  = dir_s2;
    next_dir_d   = dir_d;
    next_hold_s1 = hold_s1;
    next_hold_s2 = hold_s2;
    if (tick) begin
      next_dir_s1  = ramp_direction_pin;
      next_dir_s2  = dir_s1;
      next_dir_d   = dir_s2;
      next_hold_s1 = ramp_freeze_pin;
      next_hold_s2 = hold_s1;
    end
  end
  logic dir_fall_edge, dir_rise_edge, dir_change;
  assign dir_fall_edge = dir_d && !dir_s2;
  assign dir_rise_edge = !dir_d && dir_s2;
  assign dir_change    = dir_fall_edge || dir_rise_edge;

  // Ramp core
  swu_pkg::swu_dir_e dir, next_dir;
  logic running, next_running;
  logic [ACC_W-1:0] acc, next_acc;
  logic [TMR_W-1:0] tmr, next_tmr;

  function automatic logic [ACC_W-1:0] clamp_add(
    input logic [ACC_W-1:0] v, input logic [ACC_W-1:0] s,
    input logic [ACC_W-1:0] hi);
    logic [ACC_W:0] sum;
    sum = {1'b0, v} + {1'b0, s};
    if (sum > {1'b0, hi}) clamp_add = hi;
    else clamp_add = sum[ACC_W-1:0];
  endfunction : clamp_add

  function automatic logic [ACC_W-1:0] clamp_sub(
    input logic [ACC_W-1:0] v, input logic [ACC_W-1:0] s,
    input logic [ACC_W-1:0] lo);
    if (s > v || (v - s) < lo) clamp_sub = lo;
    else clamp_sub = v - s;
  endfunction : clamp_sub
  logic [TMR_W-1:0] reload;
  logic at_top, at_bot;
  assign at_top = (acc >= limit_upper);
  assign at_bot = (acc <= limit_lower);

  always_comb begin
    next_dir     = dir;
    next_running = running;
    next_acc     = acc;
    next_tmr     = tmr;
    reload       = (dir == swu_pkg::SWU_RISE) ? rate_rise : rate_fall;
    if (!en_q) begin
      next_running = 1'b0;
      next_tmr     = '0;
      next_acc     = limit_lower;
    end else if (clr_q) begin
      next_acc = limit_lower;
      next_tmr = '0;
    end else if (tick && !hold_s2) begin
      case (no_dwell)
        `SWU_DWELL_NORMAL: begin
          next_dir = dir_s2 ? swu_pkg::SWU_RISE : swu_pkg::SWU_FALL;
          next_running = 1'b1;
        end
        `SWU_DWELL_FALL: begin
          if (dir_fall_edge &&
              !(running && dir == swu_pkg::SWU_FALL)) begin
            next_dir = swu_pkg::SWU_FALL;
            next_running = 1'b1;
          end
        end
        `SWU_DWELL_RISE: begin
          if (dir_rise_edge &&
              !(running && dir == swu_pkg::SWU_RISE)) begin
            next_dir = swu_pkg::SWU_RISE;
            next_running = 1'b1;
          end
        end
        default: begin
          next_running = 1'b1;
          if (dir_fall_edge && dir == swu_pkg::SWU_RISE) begin
            next_dir = swu_pkg::SWU_FALL;
          end else if (dir_rise_edge && dir == swu_pkg::SWU_FALL) begin
            next_dir = swu_pkg::SWU_RISE;
          end
        end
      endcase
      if (next_dir != dir || (next_running && !running)) begin
        next_tmr = '0;
      end else if (running) begin
        if (tmr != '0) begin
          next_tmr = tmr - TMR_W'(1);
        end else begin
          next_tmr = reload - TMR_W'(1);
          if (dir == swu_pkg::SWU_RISE) begin
            next_acc = clamp_add(acc, step_rise, limit_upper);
          end else begin
            next_acc = clamp_sub(acc, step_fall, limit_lower);
          end
        end
      end
      // Limit reached handling per dwell mode
      if (no_dwell == `SWU_DWELL_FALL && running &&
          dir == swu_pkg::SWU_FALL && at_bot) begin
        next_acc = limit_upper;
        next_running = 1'b0;
      end
      if (no_dwell == `SWU_DWELL_RISE && running &&
          dir == swu_pkg::SWU_RISE && at_top) begin
        next_acc = limit_lower;
        next_running = 1'b0;
      end
      if (no_dwell == `SWU_DWELL_CONT) begin
        if (dir == swu_pkg::SWU_RISE && at_top) begin
          next_dir = swu_pkg::SWU_FALL;
        end else if (dir == swu_pkg::SWU_FALL && at_bot) begin
          next_dir = swu_pkg::SWU_RISE;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q    <= 1'b0;
      clr_q   <= 1'b0;
      dir_s1  <= 1'b0;
      dir_s2  <= 1'b0;
      dir_d   <= 1'b0;
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
      dir     <= swu_pkg::SWU_FALL;
      running <= 1'b0;
      acc     <= '0;
      tmr     <= '0;
    end else begin
      en_q    <= next_en_q;
      clr_q   <= next_clr_q;
      dir_s1  <= next_dir_s1;
      dir_s2  <= next_dir_s2;
      dir_d   <= next_dir_d;
      hold_s1 <= next_hold_s1;
      hold_s2 <= next_hold_s2;
      dir     <= next_dir;
      running <= next_running;
      acc     <= next_acc;
      tmr     <= next_tmr;
    end
  end

  // Output routing
  logic [31:0] next_freq;
  logic [15:0] next_phase;
  logic [11:0] next_amp;
  always_comb begin
    next_freq  = prof_freq;
    next_phase = prof_phase;
    next_amp   = prof_amp;
    if (en_q) begin
      if (ramp_dest == `SWU_DEST_FREQ) begin
        next_freq = acc;
      end else if (ramp_dest == `SWU_DEST_PHASE) begin
        next_phase = acc[`SWU_PHASE_W-1:0];
      end else begin
        next_amp = acc[`SWU_AMP_W-1:0];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      dds_freq  <= '0;
      dds_phase <= '0;
      dds_amp   <= '0;
    end else begin
      dds_freq  <= next_freq;
      dds_phase <= next_phase;
      dds_amp   <= next_amp;
    end
  end
  assign ramp_out    = acc;
  assign ramp_active = en_q;
  // Checks
  enable_commit_a: assert property (@(posedge clk) disable iff (rst)
    !io_update |=> en_q == $past(en_q))
    else $error("enable changed without commit");
  disabled_idle_a: assert property (@(posedge clk) disable iff (rst)
    !en_q |-> !tick ##1 (acc == $past(limit_lower) && !running))
    else $error("ramp not idle while disabled");
  limit_clamp_a: assert property (@(posedge clk) disable iff (rst)
    en_q && !clr_q && $past(en_q) && limit_upper > limit_lower &&
    $stable(limit_upper) && $stable(limit_lower) && !$past(clr_q) &&
    $past(acc) >= limit_lower && $past(acc) <= limit_upper
    |-> acc <= limit_upper && acc >= limit_lower)
    else $error("ramp outside limits");
  clear_lower_a: assert property (@(posedge clk) disable iff (rst)
    en_q && clr_q |=> acc == $past(limit_lower))
    else $error("clear did not hold lower limit");
  hold_freeze_a: assert property (@(posedge clk) disable iff (rst)
    en_q && !clr_q && hold_s2 && !en_rise |=> acc == $past(acc))
    else $error("ramp moved while held");
  freq_route_a: assert property (@(posedge clk) disable iff (rst)
    en_q && ramp_dest == `SWU_DEST_FREQ |=> dds_freq == $past(acc))
    else $error("frequency not routed");
  amp_route_a: assert property (@(posedge clk) disable iff (rst)
    en_q && ramp_dest[1] |=> dds_amp == $past(acc[11:0]) &&
    dds_phase == $past(prof_phase))
    else $error("amplitude routing wrong");
  rise_step_a: assert property (@(posedge clk) disable iff (rst)
    en_q && !clr_q && tick && !hold_s2 && running && tmr == '0 &&
    dir == swu_pkg::SWU_RISE && no_dwell == `SWU_DWELL_NORMAL &&
    dir_s2 && {1'b0, acc} + {1'b0, step_rise} <= {1'b0, limit_upper}
    |=> acc == $past(acc) + $past(step_rise))
    else $error("rising step wrong");
  cover_rise_c: cover property (@(posedge clk)
    en_q && dir == swu_pkg::SWU_RISE && at_top);
  cover_fall_c: cover property (@(posedge clk)
    en_q && dir == swu_pkg::SWU_FALL && at_bot);
  cover_cont_c: cover property (@(posedge clk)
    en_q && no_dwell == `SWU_DWELL_CONT && dir_change);
  cover_hold_c: cover property (@(posedge clk) en_q && hold_s2 && running);
endmodule : swu_sweep_unit
`default_nettype wire

// >>> verif/swu_ctrl_model.sv
// External controller model driving the direction and freeze pins
`timescale 1ns/100ps
`default_nettype none
module swu_ctrl_model (
  input  wire logic clk,       // System clock
  input  wire logic want_dir,  // Requested direction level
  input  wire logic want_hold, // Requested freeze level
  output var logic  dir_pin,   // Direction pin
  output var logic  hold_pin   // Freeze pin
);
  // Pins move away from the sampling edge, as an unrelated source would
  always @(negedge clk) begin
    dir_pin  <= want_dir;
    hold_pin <= want_hold;
  end
endmodule : swu_ctrl_model
`default_nettype wire

// >>> verif/digital_ramp_sweep_generator_tb.sv
// Self-checking bench for the sweep unit
`timescale 1ns/100ps
`default_nettype none
`include "sweep_unit_regs.svh"
module digital_ramp_sweep_generator_tb;
  localparam logic [31:0] LO = 32'h64;
  localparam logic [31:0] HI = 32'h82;
  logic clk, rst, upd, en, clr, wd, wh, dp, hp, mon;
  logic [1:0] dest, nd;
  logic [31:0] lo, up, f, ro, df;
  logic [15:0] dph, pph;
  logic [11:0] dam;
  logic act;
  int n_fail, num_checks;

  swu_ctrl_model i_ctl (.clk(clk), .want_dir(wd), .want_hold(wh),
    .dir_pin(dp), .hold_pin(hp));
  swu_sweep_unit i_dut (.clk(clk), .rst(rst), .io_update(upd),
    .ramp_enable(en), .ramp_clear(clr), .ramp_dest(dest), .no_dwell(nd),
    .step_rise(32'h3), .step_fall(32'h7),
    .rate_rise(16'h3), .rate_fall(16'h2), .limit_upper(up),
    .limit_lower(lo), .ramp_direction_pin(dp), .ramp_freeze_pin(hp),
    .prof_freq(f), .prof_phase(pph), .prof_amp(12'hABC),
    .ramp_out(ro), .dds_freq(df), .dds_phase(dph), .dds_amp(dam),
    .ramp_active(act));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Mode 0 equal, 1 below, 2 changed
  task automatic wt(input logic [31:0] v, input int b, input int m);
    for (int i = 0; i < b; i++) begin
      @(negedge clk);
      if (m == 0 ? ro === v : m == 1 ? ro < v : ro !== v) return;
    end
    n_fail++;
    $display("BAD wait exp %h got %h", v, ro);
    results();
  endtask : wt

  task automatic commit();
    upd = 1'b1;
    cyc(1);
    upd = 1'b0;
    cyc(2);
  endtask : commit

  task automatic gap(input int ec, input logic [31:0] ed);
    logic [31:0] v0;
    int n;
    wt(ro, 400, 2);
    v0 = ro;
    n = 0;
    while (ro === v0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (ro !== v0) begin
      chk("interval", 32'(ec), 32'(n));
      chk("step", ed, ro - v0);
    end else begin
      n_fail++;
      $display("BAD gap exp %h got %h", v0 + ed, ro);
      results();
    end
  endtask : gap

  // Range watch while the ramp runs
  always @(negedge clk) begin
    if (mon && act === 1'b1 && (ro < lo || ro > HI)) begin
      n_fail++;
      $display("BAD range exp %h got %h", HI, ro);
    end
  end

  task automatic s_off();
    chk("active", 32'h0, 32'(act));
    chk("out", LO, ro);
    chk("freq", f, df);
    wd = 1'b1;
    cyc(100);
    chk("idle", LO, ro);
  endtask : s_off

  task automatic s_norm();
    en = 1'b1;
    commit();
    chk("active", 32'h1, 32'(act));
    mon = 1'b1;
    wt(LO + 32'h6, 800, 0);
    gap(48, 32'h3);
    wt(HI, 800, 0);
    cyc(200);
    chk("hold hi", HI, ro);
    wd = 1'b0;
    gap(32, 32'hFFFF_FFF9);
    wt(LO, 800, 0);
  endtask : s_norm

  task automatic s_hold();
    logic [31:0] v;
    wd = 1'b1;
    wt(LO + 32'hC, 800, 0);
    wh = 1'b1;
    cyc(100);
    v = ro;
    cyc(300);
    chk("frozen", v, ro);
    wh = 1'b0;
    wt(v, 400, 2);
  endtask : s_hold

  task automatic s_clear();
    logic [31:0] e;
    wt(HI, 800, 0);
    clr = 1'b1;
    cyc(20);
    chk("pending", HI, ro);
    commit();
    chk("cleared", LO, ro);
    mon = 1'b0;
    lo = 32'h0001_2345;
    for (int d = 0; d < 4; d++) begin
      dest = 2'(d);
      cyc(4);
      e = d == 0 ? lo : f;
      chk("freq", e, df);
      e = d == 1 ? 32'h2345 : 32'hBEEF;
      chk("phase", e, 32'(dph));
      e = d > 1 ? 32'h345 : 32'hABC;
      chk("amp", e, 32'(dam));
    end
    lo = LO;
    dest = `SWU_DEST_FREQ;
    cyc(4);
    chk("cleared", LO, ro);
    clr = 1'b0;
    commit();
    mon = 1'b1;
  endtask : s_clear

  task automatic s_modes();
    wt(HI, 800, 0);
    nd = `SWU_DWELL_FALL;
    wd = 1'b0;
    cyc(100);
    wd = 1'b1;
    wt(LO, 800, 0);
    wt(HI, 60, 0);
    nd = `SWU_DWELL_RISE;
    wd = 1'b0;
    cyc(60);
    wd = 1'b1;
    wt(LO, 1200, 0);
    wd = 1'b0;
    cyc(60);
    wd = 1'b1;
    cyc(100);
    wd = 1'b0;
    wt(HI, 800, 0);
    wt(LO, 60, 0);
    wd = 1'b1;
    nd = `SWU_DWELL_CONT;
    wt(HI, 800, 0);
    wt(LO, 800, 0);
    wt(LO + 32'hC, 800, 0);
    wd = 1'b0;
    wt(LO + 32'hC, 200, 1);
  endtask : s_modes

  task automatic s_stop();
    logic [31:0] v;
    en = 1'b0;
    commit();
    chk("active", 32'h0, 32'(act));
    chk("freq", f, df);
    v = ro;
    wd = 1'b1;
    wh = 1'b1;
    cyc(100);
    chk("ignored", v, ro);
  endtask : s_stop

  initial begin
    rst = 1'b1;
    {upd, en, clr, wd, wh, mon} = '0;
    dest = `SWU_DEST_FREQ;
    nd = `SWU_DWELL_NORMAL;
    lo = LO;
    f = 32'h1234_5678;
    up = HI;
    pph = 16'hBEEF;
    n_fail = 0;
    num_checks = 0;
    cyc(3);
    rst = 1'b0;
    cyc(2);
    s_off();
    s_norm();
    s_hold();
    s_clear();
    s_modes();
    s_stop();
    results();
  end
endmodule : digital_ramp_sweep_generator_tb
`default_nettype wire
